//--- bp_pkg.sv
// constants for the per-hart breakpoint trigger block
// assumes a 32-bit core address space and a 2-bit trigger csr select
package bp_pkg;
    localparam int XLEN = 32;
    localparam int NUM_TRIG = 8;
    localparam int IDX_W = 3;

    // csr select codes of the trigger csr group
    localparam logic [1:0] CSR_SELECT = 2'h0;
    localparam logic [1:0] CSR_DATA1 = 2'h1;
    localparam logic [1:0] CSR_DATA2 = 2'h2;
    localparam logic [1:0] CSR_DATA3 = 2'h3;

    // field positions of trigger_data_word1
    localparam int POS_LOAD = 0;
    localparam int POS_STORE = 1;
    localparam int POS_FETCH = 2;
    localparam int POS_USER = 3;
    localparam int POS_SUPER = 4;
    localparam int POS_MACH = 6;
    localparam int POS_MATCH = 7;
    localparam int POS_CHAIN = 11;
    localparam int POS_ACTION = 12;
    localparam int POS_MASKMAX = 21;
    localparam int POS_DMODE = 27;
    localparam int POS_TYPE = 28;

    localparam logic [3:0] TYPE_ADDR_MATCH = 4'h2;
    localparam logic [3:0] TYPE_NONE = 4'h0;
    localparam logic [5:0] MASKMAX_RST = 6'h04;

    localparam logic [5:0] ACTION_EXC = 6'h00;
    localparam logic [5:0] ACTION_DEBUG = 6'h01;

    localparam logic [3:0] MATCH_EXACT = 4'h0;
    localparam logic [3:0] MATCH_NAPOT = 4'h1;
    localparam logic [3:0] MATCH_GE = 4'h2;
    localparam logic [3:0] MATCH_LT = 4'h3;

    localparam logic [1:0] PRIV_U = 2'h0;
    localparam logic [1:0] PRIV_S = 2'h1;
    localparam logic [1:0] PRIV_M = 2'h3;

    localparam logic [1:0] KIND_LOAD = 2'h0;
    localparam logic [1:0] KIND_STORE = 2'h1;
    localparam logic [1:0] KIND_FETCH = 2'h2;

    localparam logic [XLEN-1:0] CTRL_RST = 32'h0000_0000;
    localparam logic [XLEN-1:0] ADDR_RST = 32'h0000_0000;
    localparam logic [IDX_W-1:0] INDEX_RST = 3'h0;
endpackage

//--- bp_compare.sv
// one trigger's address and qualifier comparison, purely combinational
// assumes fields arrive already legalised by the register logic
`timescale 1ns/1ps
module bp_compare
(
    input wire logic [3:0] match_type,
    input wire logic [2:0] kind_en,
    input wire logic [2:0] priv_en,
    input wire logic [31:0] match_addr,
    input wire logic [31:0] acc_addr,
    input wire logic [1:0] acc_kind,
    input wire logic [1:0] acc_priv,
    output logic hit
);
    logic [31:0] napot_mask;
    logic kind_ok;
    logic priv_ok;
    logic addr_ok;

    // trailing ones plus the terminating zero form the don't-care bits
    assign napot_mask = match_addr ^ (match_addr + 32'h0000_0001);

    always_comb
    begin
        case (acc_kind)
            bp_pkg::KIND_LOAD: kind_ok = kind_en[0];
            bp_pkg::KIND_STORE: kind_ok = kind_en[1];
            bp_pkg::KIND_FETCH: kind_ok = kind_en[2];
            default: kind_ok = 1'b0;
        endcase
        case (acc_priv)
            bp_pkg::PRIV_U: priv_ok = priv_en[0];
            bp_pkg::PRIV_S: priv_ok = priv_en[1];
            bp_pkg::PRIV_M: priv_ok = priv_en[2];
            default: priv_ok = 1'b0;
        endcase
        case (match_type)
            bp_pkg::MATCH_EXACT: addr_ok = (acc_addr == match_addr);
            bp_pkg::MATCH_NAPOT:
                addr_ok = ((acc_addr & ~napot_mask) ==
                           (match_addr & ~napot_mask));
            bp_pkg::MATCH_GE: addr_ok = (acc_addr >= match_addr);
            bp_pkg::MATCH_LT: addr_ok = (acc_addr < match_addr);
            default: addr_ok = 1'b0;
        endcase
    end

    assign hit = kind_ok & priv_ok & addr_ok;
endmodule

//--- breakpoint_match_control.sv
// per-hart breakpoint triggers behind the trigger csr indirection
// assumes csr and access requests come from core logic on MCLK
// Contract
// - type field of word1 reads constant 2; writes to it are ignored.
// - action 0 raises breakpoint exception, 1 enters debug; resets to 0.
// - load, store and fetch enables at bits 0, 1, 2, any combination.
// - machine bit 6, supervisor bit 4, user bit 3 gate matches by mode.
// - match field bits 10:7 picks exact, napot or range compare.
// - napot size comes from trailing ones in the match address.
// - read-only maskmax field bits 26:21 reads 4.
// - largest napot range (31 trailing ones) compares no address bits.
// - chain bit 11 makes next trigger fire only if both match.
// - timing bit 18 and select bit 19 always read zero.
// - machine-mode access to a debug-only trigger is illegal.
// - eight triggers via index; word1, word2 visible, word3 reserved.
// - debug-claimed trigger shows type 0 to machine mode.
// - exception reports cause address; debug entry leaves it alone.
`timescale 1ns/1ps
module breakpoint_match_control
#(
    parameter int NUM_TRIG = bp_pkg::NUM_TRIG
)
(
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic CSR_VALID,
    input wire logic CSR_WE,
    input wire logic [1:0] CSR_SEL,
    input wire logic [31:0] CSR_WDATA,
    input wire logic DEBUG_MODE,
    output logic [31:0] CSR_RDATA,
    output logic CSR_DONE,
    output logic CSR_ILLEGAL,
    input wire logic ACC_VALID,
    input wire logic [1:0] ACC_KIND,
    input wire logic [1:0] ACC_PRIV,
    input wire logic [31:0] ACC_ADDR,
    output logic BP_EXC,
    output logic BP_DEBUG,
    output logic [31:0] BP_TVAL
);
    localparam int IW = bp_pkg::IDX_W;

    // the index register cannot address more triggers than its width allows
    if (NUM_TRIG < 2 || NUM_TRIG > (1 << IW))
    begin : bad_num_trig
        $error("NUM_TRIG out of range");
    end

    // =========================================================
    // trigger storage
    // =========================================================
    logic [IW-1:0] index_q;
    logic [2:0] kind_en_q [NUM_TRIG];
    logic [2:0] priv_en_q [NUM_TRIG];
    logic [3:0] match_q [NUM_TRIG];
    logic chain_q [NUM_TRIG];
    logic [5:0] action_q [NUM_TRIG];
    logic dmode_q [NUM_TRIG];
    logic [31:0] addr_q [NUM_TRIG];
    logic [NUM_TRIG-1:0] hit;
    logic [NUM_TRIG-1:0] fire;

    logic locked;
    logic wr_ok;
    logic [3:0] wr_match;
    logic [5:0] wr_action;

    // a debug-only trigger is out of reach of machine-mode code
    assign locked = dmode_q[index_q] & ~DEBUG_MODE;
    assign wr_ok = CSR_VALID & CSR_WE & ~locked;
    // unsupported match and action codes fall back to the safe default
    assign wr_match = (CSR_WDATA[bp_pkg::POS_MATCH +: 4] > bp_pkg::MATCH_LT)
        ? bp_pkg::MATCH_EXACT : CSR_WDATA[bp_pkg::POS_MATCH +: 4];
    assign wr_action =
        (CSR_WDATA[bp_pkg::POS_ACTION +: 6] > bp_pkg::ACTION_DEBUG)
        ? bp_pkg::ACTION_EXC : CSR_WDATA[bp_pkg::POS_ACTION +: 6];

    // =========================================================
    // index register
    // =========================================================
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
            index_q <= bp_pkg::INDEX_RST;
        else if (CSR_VALID && CSR_WE && CSR_SEL == bp_pkg::CSR_SELECT &&
                 CSR_WDATA < 32'(NUM_TRIG))
            index_q <= CSR_WDATA[IW-1:0];
    end

    // =========================================================
    // per-trigger registers and comparators
    // =========================================================
    genvar g;
    generate
        for (g = 0; g < NUM_TRIG; g++)
        begin : trig
            logic sel;
            assign sel = (index_q == IW'(g));

            always_ff @(posedge MCLK or negedge RST_B)
            begin
                if (!RST_B)
                begin
                    kind_en_q[g] <= 3'h0;
                    priv_en_q[g] <= 3'h0;
                    match_q[g] <= bp_pkg::MATCH_EXACT;
                    chain_q[g] <= 1'b0;
                    action_q[g] <= bp_pkg::ACTION_EXC;
                    dmode_q[g] <= 1'b0;
                end
                else if (wr_ok && sel && CSR_SEL == bp_pkg::CSR_DATA1)
                begin
                    // bits 5, 18, 19, 20 and the type are not stored
                    kind_en_q[g] <= CSR_WDATA[2:0];
                    priv_en_q[g] <= {CSR_WDATA[bp_pkg::POS_MACH],
                                     CSR_WDATA[bp_pkg::POS_SUPER],
                                     CSR_WDATA[bp_pkg::POS_USER]};
                    match_q[g] <= wr_match;
                    chain_q[g] <= CSR_WDATA[bp_pkg::POS_CHAIN];
                    action_q[g] <= wr_action;
                    // only debug-mode code may claim a trigger
                    dmode_q[g] <= CSR_WDATA[bp_pkg::POS_DMODE] & DEBUG_MODE;
                end
            end

            always_ff @(posedge MCLK or negedge RST_B)
            begin
                if (!RST_B)
                    addr_q[g] <= bp_pkg::ADDR_RST;
                else if (wr_ok && sel && CSR_SEL == bp_pkg::CSR_DATA2)
                    addr_q[g] <= CSR_WDATA;
            end

            bp_compare u_cmp
            (
                .match_type(match_q[g]),
                .kind_en(kind_en_q[g]),
                .priv_en(priv_en_q[g]),
                .match_addr(addr_q[g]),
                .acc_addr(ACC_ADDR),
                .acc_kind(ACC_KIND),
                .acc_priv(ACC_PRIV),
                .hit(hit[g])
            );

            // a chaining trigger never fires alone; its partner needs both
            if (g == 0)
            begin : first
                assign fire[g] = hit[g] & ~chain_q[g];
            end
            else
            begin : rest
                assign fire[g] = hit[g] & ~chain_q[g] &
                    (~chain_q[g-1] | hit[g-1]);
            end
        end
    endgenerate

    // =========================================================
    // csr read path, answered one cycle after the request
    // =========================================================
    logic [31:0] word1;
    logic [31:0] rdata_d;

    always_comb
    begin
        word1 = 32'h0000_0000;
        word1[bp_pkg::POS_TYPE +: 4] = bp_pkg::TYPE_ADDR_MATCH;
        word1[bp_pkg::POS_DMODE] = dmode_q[index_q];
        word1[bp_pkg::POS_MASKMAX +: 6] = bp_pkg::MASKMAX_RST;
        word1[bp_pkg::POS_ACTION +: 6] = action_q[index_q];
        word1[bp_pkg::POS_CHAIN] = chain_q[index_q];
        word1[bp_pkg::POS_MATCH +: 4] = match_q[index_q];
        word1[bp_pkg::POS_MACH] = priv_en_q[index_q][2];
        word1[bp_pkg::POS_SUPER] = priv_en_q[index_q][1];
        word1[bp_pkg::POS_USER] = priv_en_q[index_q][0];
        word1[2:0] = kind_en_q[index_q];
        // bits 5, 18, 19, 20 stay zero above
        rdata_d = 32'h0000_0000;
        if (locked)
            rdata_d = 32'h0000_0000;
        else
        begin
            case (CSR_SEL)
                bp_pkg::CSR_SELECT: rdata_d = 32'(index_q);
                bp_pkg::CSR_DATA1: rdata_d = word1;
                bp_pkg::CSR_DATA2: rdata_d = addr_q[index_q];
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            CSR_RDATA <= 32'h0000_0000;
            CSR_DONE <= 1'b0;
            CSR_ILLEGAL <= 1'b0;
        end
        else
        begin
            CSR_DONE <= CSR_VALID;
            CSR_ILLEGAL <= CSR_VALID & locked &
                (CSR_SEL != bp_pkg::CSR_SELECT);
            if (CSR_VALID && !CSR_WE)
                CSR_RDATA <= (CSR_SEL == bp_pkg::CSR_SELECT)
                    ? 32'(index_q) : rdata_d;
        end
    end

    // =========================================================
    // trap generation, one cycle after the access is presented
    // =========================================================
    logic want_exc;
    logic want_dbg;

    always_comb
    begin
        want_exc = 1'b0;
        want_dbg = 1'b0;
        for (int i = 0; i < NUM_TRIG; i++)
        begin
            if (fire[i] && action_q[i] == bp_pkg::ACTION_DEBUG)
                want_dbg = 1'b1;
            if (fire[i] && action_q[i] == bp_pkg::ACTION_EXC)
                want_exc = 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            BP_EXC <= 1'b0;
            BP_DEBUG <= 1'b0;
        end
        else
        begin
            // triggers are muted while the hart already sits in debug mode
            BP_DEBUG <= ACC_VALID & ~DEBUG_MODE & want_dbg;
            BP_EXC <= ACC_VALID & ~DEBUG_MODE & ~want_dbg & want_exc;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
            BP_TVAL <= 32'h0000_0000;
        else if (ACC_VALID && !DEBUG_MODE && !want_dbg && want_exc)
            BP_TVAL <= ACC_ADDR;
    end
endmodule

//--- bp_props.sv
// assertions on the breakpoint trigger block's ports
// assumes binding to breakpoint_match_control
`timescale 1ns/1ps
module bp_props
(
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic CSR_VALID,
    input wire logic CSR_WE,
    input wire logic [1:0] CSR_SEL,
    input wire logic DEBUG_MODE,
    input wire logic [31:0] CSR_RDATA,
    input wire logic CSR_DONE,
    input wire logic CSR_ILLEGAL,
    input wire logic ACC_VALID,
    input wire logic [31:0] ACC_ADDR,
    input wire logic BP_EXC,
    input wire logic BP_DEBUG,
    input wire logic [31:0] BP_TVAL
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    logic rd1;
    assign rd1 = CSR_VALID && !CSR_WE && CSR_SEL == bp_pkg::CSR_DATA1;
    // ========================================
    // csr side
    done_pulse_a: assert property (CSR_VALID |=> CSR_DONE)
        else $error("csr request not answered next cycle");
    done_cause_a: assert property (CSR_DONE |-> $past(CSR_VALID))
        else $error("csr done without request");
    index_legal_a: assert property (CSR_VALID && CSR_SEL == 2'h0
        |=> !CSR_ILLEGAL) else $error("index access flagged illegal");
    type_read_a: assert property (rd1 |=> CSR_ILLEGAL
        || CSR_RDATA[31:28] == 4'h2) else $error("type field not 2");
    maskmax_a: assert property (rd1 |=> CSR_ILLEGAL
        || CSR_RDATA[26:21] == 6'h04) else $error("maskmax field not 4");
    fixed_zero_a: assert property (rd1 |=> CSR_RDATA[20:18] == 3'h0
        && !CSR_RDATA[5] && CSR_RDATA[17:13] == 5'h00)
        else $error("fixed field not zero");
    hidden_zero_a: assert property (CSR_ILLEGAL && !$past(CSR_WE)
        |-> CSR_RDATA == 32'h0) else $error("claimed trigger leaked data");
    // ========================================
    // trigger side
    fire_cause_a: assert property (BP_EXC || BP_DEBUG
        |-> $past(ACC_VALID) && !$past(DEBUG_MODE))
        else $error("trigger fired without access");
    one_pulse_a: assert property (!(BP_EXC && BP_DEBUG))
        else $error("both actions at once");
    tval_load_a: assert property (BP_EXC
        |-> BP_TVAL == $past(ACC_ADDR))
        else $error("tval not access address");
    tval_hold_a: assert property (!BP_EXC |-> $stable(BP_TVAL))
        else $error("tval changed without exception");
    exc_c: cover property (BP_EXC);
    dbg_c: cover property (BP_DEBUG);
    ill_c: cover property (CSR_ILLEGAL);
endmodule

//--- core_model.sv
// core pipeline model issuing one load, store or fetch per call
// assumes the caller owns MCLK
`timescale 1ns/1ps
module core_model
(
    input wire logic MCLK,
    output logic ACC_VALID,
    output logic [1:0] ACC_KIND,
    output logic [1:0] ACC_PRIV,
    output logic [31:0] ACC_ADDR
);
    initial
    begin
        ACC_VALID = 1'b0;
        ACC_KIND = 2'h3;
        ACC_PRIV = 2'h2;
        ACC_ADDR = 32'h0;
    end
    task automatic issue(input logic [1:0] k, input logic [1:0] p,
        input logic [31:0] a);
        @(posedge MCLK);
        #1;
        ACC_VALID = 1'b1;
        ACC_KIND = k;
        ACC_PRIV = p;
        ACC_ADDR = a;
        @(posedge MCLK);
        #1;
        // idle lines carry junk so nothing can lean on stale values
        ACC_VALID = 1'b0;
        ACC_KIND = 2'h3;
        ACC_PRIV = 2'h2;
        ACC_ADDR = ~a;
    endtask
endmodule

//--- test_breakpoint_match_control.sv
// self-checking bench for the breakpoint trigger block
// assumes core_model and bp_props compiled first
`timescale 1ns/1ps
module test_breakpoint_match_control;
    logic mclk = 0, rst_b = 0, valid = 0, we = 0, dbg = 0;
    logic [1:0] sel = 2'h0;
    logic [31:0] wd = 32'h0, rd;
    logic ill;
    logic av;
    logic [1:0] ak, ap;
    logic [31:0] aa, rdata, tval;
    logic done, illegal, exc, dbgo;
    int err_total = 0, total_checks = 0;
    breakpoint_match_control dut(.MCLK(mclk), .RST_B(rst_b),
        .CSR_VALID(valid), .CSR_WE(we), .CSR_SEL(sel), .CSR_WDATA(wd),
        .DEBUG_MODE(dbg), .CSR_RDATA(rdata), .CSR_DONE(done),
        .CSR_ILLEGAL(illegal), .ACC_VALID(av), .ACC_KIND(ak),
        .ACC_PRIV(ap), .ACC_ADDR(aa), .BP_EXC(exc), .BP_DEBUG(dbgo),
        .BP_TVAL(tval));
    core_model core(.MCLK(mclk), .ACC_VALID(av), .ACC_KIND(ak),
        .ACC_PRIV(ap), .ACC_ADDR(aa));
    always #2 mclk = ~mclk;
    // ========================================
    // compares and bus tasks
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic csr(input logic w, input logic [1:0] s,
        input logic [31:0] d);
        @(posedge mclk);
        #1;
        valid = 1;
        we = w;
        sel = s;
        wd = d;
        @(posedge mclk);
        #1;
        valid = 0;
        rd = rdata;
        ill = illegal;
        chk32({31'h0, done}, 32'h1);
    endtask
    task automatic trig(input logic [2:0] i, input logic [31:0] c,
        input logic [31:0] a);
        csr(1, 2'h0, {29'h0, i});
        csr(1, 2'h1, c);
        csr(1, 2'h2, a);
    endtask
    task automatic acc(input logic [1:0] k, input logic [1:0] p,
        input logic [31:0] a, input logic [1:0] e);
        core.issue(k, p, a);
        chk32({30'h0, dbgo, exc}, {30'h0, e});
    endtask
    // ========================================
    // scenarios
    task automatic t_fields;
        csr(0, 2'h1, 32'h0);
        chk32(rd, 32'h2080_0000);
        csr(1, 2'h1, 32'hFFFF_FFFF);
        csr(0, 2'h1, 32'h0);
        chk32(rd, 32'h2080_085F);
        csr(1, 2'h3, 32'hFFFF_FFFF);
        csr(0, 2'h3, 32'h0);
        chk32(rd, 32'h0);
        csr(1, 2'h0, 32'h8);
        csr(0, 2'h0, 32'h0);
        chk32(rd, 32'h0);
        trig(0, 32'h0, 32'h0);
    endtask
    task automatic t_exact;
        trig(0, 32'h41, 32'h100);
        acc(2'h0, 2'h3, 32'h100, 2'h1);
        chk32(tval, 32'h100);
        acc(2'h1, 2'h3, 32'h100, 2'h0);
        acc(2'h0, 2'h1, 32'h100, 2'h0);
        acc(2'h0, 2'h3, 32'h101, 2'h0);
        // store with supervisor and machine enabled, load off
        trig(0, 32'h52, 32'h100);
        acc(2'h1, 2'h1, 32'h100, 2'h1);
        acc(2'h0, 2'h1, 32'h100, 2'h0);
        acc(2'h1, 2'h0, 32'h100, 2'h0);
    endtask
    task automatic t_napot;
        trig(0, 32'h8C, 32'h1000_0003);
        acc(2'h2, 2'h0, 32'h1000_0007, 2'h1);
        acc(2'h2, 2'h0, 32'h1000_0008, 2'h0);
        acc(2'h2, 2'h1, 32'h1000_0000, 2'h0);
        trig(0, 32'h8C, 32'h3FFF_FFFF);
        acc(2'h2, 2'h0, 32'h7FFF_FFF0, 2'h1);
        acc(2'h2, 2'h0, 32'h8000_0000, 2'h0);
    endtask
    task automatic t_action;
        trig(0, 32'h1041, 32'h200);
        acc(2'h0, 2'h3, 32'h200, 2'h2);
        chk32(tval, 32'h7FFF_FFF0);
        dbg = 1;
        acc(2'h0, 2'h3, 32'h200, 2'h0);
        dbg = 0;
        trig(0, 32'h0, 32'h0);
    endtask
    task automatic t_chain;
        // low bound ge with chain, high bound lt one past the range
        trig(0, 32'h941, 32'h2000);
        trig(1, 32'h1C1, 32'h2010);
        acc(2'h0, 2'h3, 32'h2000, 2'h1);
        acc(2'h0, 2'h3, 32'h200F, 2'h1);
        acc(2'h0, 2'h3, 32'h2010, 2'h0);
        acc(2'h0, 2'h3, 32'h1FFF, 2'h0);
        trig(1, 32'h0, 32'h0);
    endtask
    task automatic t_dmode;
        dbg = 1;
        trig(2, 32'h0800_0041, 32'h300);
        dbg = 0;
        csr(0, 2'h1, 32'h0);
        chk32({rd[31:1], ill}, 32'h1);
        csr(0, 2'h2, 32'h0);
        chk32({31'h0, ill}, 32'h1);
        // a machine-mode write to a claimed trigger must not land
        csr(1, 2'h2, 32'hDEAD_BEEF);
        chk32({31'h0, ill}, 32'h1);
        dbg = 1;
        csr(0, 2'h2, 32'h0);
        chk32(rd, 32'h300);
        csr(0, 2'h1, 32'h0);
        chk32(rd, 32'h2880_0041);
        dbg = 0;
        csr(1, 2'h0, 32'h0);
        chk32({31'h0, ill}, 32'h0);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge mclk);
        #1;
        rst_b = 1;
        t_fields();
        t_exact();
        t_napot();
        t_action();
        t_chain();
        t_dmode();
        summarize();
    end
    initial
    begin
        #20000;
        err_total++;
        summarize();
    end
endmodule
bind breakpoint_match_control bp_props u_props(.MCLK(MCLK), .RST_B(RST_B),
    .CSR_VALID(CSR_VALID), .CSR_WE(CSR_WE), .CSR_SEL(CSR_SEL),
    .DEBUG_MODE(DEBUG_MODE), .CSR_RDATA(CSR_RDATA), .CSR_DONE(CSR_DONE),
    .CSR_ILLEGAL(CSR_ILLEGAL), .ACC_VALID(ACC_VALID), .ACC_ADDR(ACC_ADDR),
    .BP_EXC(BP_EXC), .BP_DEBUG(BP_DEBUG), .BP_TVAL(BP_TVAL));
